// *** rtl/slus_map.vh ***
`ifndef SLUS_MAP_VH
`define SLUS_MAP_VH
// ****************************************
// register map
// ****************************************
`define SLUS_ADDR_CTRL 12'h000
`define SLUS_ADDR_VERS 12'h004
`define SLUS_ADDR_STAT 12'h008
`define SLUS_ADDR_LOAD 12'h00C
// ctrl fields
`define SLUS_CTRL_OPTSEL 0
`define SLUS_CTRL_RESET 32'h0000_0000
// load register fields
`define SLUS_LOAD_MCU_DONE 0
`define SLUS_LOAD_BIT_FOUND 1
`define SLUS_LOAD_BIT_DONE 2
`define SLUS_LOAD_NOFILE 3
`define SLUS_LOAD_STATUS_DONE 4
// version reset value: arbitrary neutral value
`define SLUS_VERS_RESET 32'h0000_1010
// ****************************************
// timing
// ****************************************
`define SLUS_CLK_HZ 40000000
`define SLUS_STEP_MS 150
`define SLUS_SHOW_MS 3000
`define SLUS_PAUSE_MS 500
`define SLUS_GAP_MS 300
`define SLUS_FLASH_MS 250
`define SLUS_LED_NUM 4'hC
`endif

// *** rtl/slus_tick.v ***
`default_nettype none
// ****************************************
// millisecond enable divider
// ****************************************
module slus_tick #(
  parameter integer DIV = 40000
) (
  input wire clk_in,
  input wire rst_in,
  output reg tick_out
);
  reg [15:0] cnt_q;
  // count clocks, pulse once per period
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/slus_count.v ***
`default_nettype none
// ****************************************
// version count to bar of four leds
// ****************************************
module slus_count (
  input wire [3:0] major_in,
  input wire [3:0] minor_in,
  output wire [7:0] bar_out
);
  function [3:0] to_bar;
    input [3:0] n;
    begin
      case (n)
        4'h0: to_bar = 4'b0000;
        4'h1: to_bar = 4'b0001;
        4'h2: to_bar = 4'b0011;
        4'h3: to_bar = 4'b0111;
        default: to_bar = 4'b1111;
      endcase
    end
  endfunction
  // upper row major (min one), lower row minor
  assign bar_out = {to_bar((major_in == 4'h0) ? 4'h1 : major_in), to_bar(minor_in)};
endmodule
`default_nettype wire

// *** rtl/slus_seq.v ***
// Function
// RQ1: at power-up every front led lights briefly in fixed order
// RQ2: after the walk test the power led lights and stays lit
// RQ3: usb led lights next while audio leds show controller version
// RQ4: upper row shows major version as count, one to four
// RQ5: lower row shows minor version as count, zero to four
// RQ6: usb led goes off, then logic firmware version is shown
// RQ7: after a pause normal indication; usb led only on transfers
// RQ8: sdi led lights when selected input has a valid signal
// RQ9: data led lights when local remote-bus data is received
// RQ10: each audio led lights at or above presence threshold
// RQ11: controller image on drive loads first, then normal power-up
// RQ12: logic image looked for after power-up; switch sampling paused
// RQ13: usb led flashes while logic image transfers
// RQ14: after logic load usb led steady and logic chip reboots
// RQ15: status report file written whenever a drive is attached; the code requests it only when a flash drive is attached
// RQ16: update leaves stored images untouched when none on drive
// RQ17: host talks only to flash drives
// RQ18: phase lengths come from parameterised counters
//
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none
`include "slus_map.vh"
module slus_seq #(
  parameter integer STEP_MS = `SLUS_STEP_MS,
  parameter integer SHOW_MS = `SLUS_SHOW_MS,
  parameter integer PAUSE_MS = `SLUS_PAUSE_MS,
  parameter integer GAP_MS = `SLUS_GAP_MS,
  parameter integer FLASH_MS = `SLUS_FLASH_MS,
  parameter integer MS_DIV = `SLUS_CLK_HZ / 1000
) (
  input wire clk_in,
  input wire rst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // external status pins
  input wire drive_present_in,
  input wire drive_is_flash_in,
  input wire mcu_file_in,
  input wire mcu_load_done_in,
  input wire bit_file_in,
  input wire bit_load_done_in,
  input wire xfer_active_in,
  input wire sdi_coax_ok_in,
  input wire sdi_opt_ok_in,
  input wire rs485_local_in,
  input wire [7:0] audio_present_in,
  input wire [7:0] cfg_sw_in,
  // outputs
  output reg led_power_out,
  output reg led_usb_out,
  output reg led_sdi_out,
  output reg led_data_out,
  output reg [7:0] led_audio_out,
  output reg mcu_load_req_out,
  output reg bit_load_req_out,
  output reg logic_reboot_out,
  output reg status_write_req_out,
  output reg image_load_en_out,
  output reg usb_host_en_out,
  output reg [7:0] cfg_sw_out
);
  // ****************************************
  // states
  // ****************************************
  localparam [8:0] S_BOOT = 9'b000000001;
  localparam [8:0] S_WALK = 9'b000000010;
  localparam [8:0] S_GAP = 9'b000000100;
  localparam [8:0] S_MCUV = 9'b000001000;
  localparam [8:0] S_BITV = 9'b000010000;
  localparam [8:0] S_PAUSE = 9'b000100000;
  localparam [8:0] S_NORM = 9'b001000000;
  localparam [8:0] S_LOAD = 9'b010000000;
  localparam [8:0] S_DONE = 9'b100000000;
  localparam [15:0] STEP_T = STEP_MS[15:0];
  localparam [15:0] SHOW_T = SHOW_MS[15:0];
  localparam [15:0] PAUSE_T = PAUSE_MS[15:0];
  localparam [15:0] GAP_T = GAP_MS[15:0];
  localparam [15:0] FLASH_T = FLASH_MS[15:0];
  localparam [3:0] LED_LAST = `SLUS_LED_NUM - 4'h1;

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [25:0] raw_w = {drive_present_in, drive_is_flash_in, mcu_file_in, mcu_load_done_in,
    bit_file_in, bit_load_done_in, xfer_active_in, sdi_coax_ok_in, sdi_opt_ok_in,
    rs485_local_in, audio_present_in, cfg_sw_in};
  reg [25:0] sync1_q;
  reg [25:0] sync2_q;
  // two flops on every pin input
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 26'h000_0000;
      sync2_q <= 26'h000_0000;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
    end
  end
  wire drv_w = sync2_q[25];
  wire flash_w = sync2_q[24];
  wire mcuf_w = sync2_q[23];
  wire mcud_w = sync2_q[22];
  wire bitf_w = sync2_q[21];
  wire bitd_w = sync2_q[20];
  wire xfer_w = sync2_q[19];
  wire coax_w = sync2_q[18];
  wire opt_w = sync2_q[17];
  wire rs_w = sync2_q[16];
  wire [7:0] aud_w = sync2_q[15:8];
  wire [7:0] sw_w = sync2_q[7:0];
  wire drv_ok_w = drv_w & flash_w; // [RQ17]

  // ****************************************
  // registers
  // ****************************************
  reg [8:0] st_q;
  reg [31:0] ctrl_q;
  reg [31:0] vers_q;
  reg mcu_done_q;
  reg bit_found_q;
  reg bit_done_q;
  reg nofile_q;
  reg stat_done_q;
  wire apb_acc_w = psel_in & penable_in;
  wire [31:0] load_w = {27'h000_0000, stat_done_q, nofile_q, bit_done_q, bit_found_q,
    mcu_done_q};
  // apb write and read, zero wait state
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `SLUS_CTRL_RESET;
      vers_q <= `SLUS_VERS_RESET;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (psel_in & ~penable_in) begin
        case (paddr_in)
          `SLUS_ADDR_CTRL: prdata_out <= ctrl_q;
          `SLUS_ADDR_VERS: prdata_out <= vers_q;
          `SLUS_ADDR_STAT: prdata_out <= {23'h00_0000, st_q};
          `SLUS_ADDR_LOAD: prdata_out <= load_w;
          default: begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b1;
          end
        endcase
      end
      if (apb_acc_w & pwrite_in & pready_out) begin
        if (paddr_in == `SLUS_ADDR_CTRL) ctrl_q <= pwdata_in;
        if (paddr_in == `SLUS_ADDR_VERS) vers_q <= pwdata_in;
      end
    end
  end

  // ****************************************
  // timing and version bars
  // ****************************************
  wire ms_w;
  slus_tick #(.DIV(MS_DIV)) u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_out(ms_w)
  );
  wire [7:0] mcu_bar_w;
  wire [7:0] bit_bar_w;
  slus_count u_mcu (
    .major_in(vers_q[15:12]),
    .minor_in(vers_q[11:8]),
    .bar_out(mcu_bar_w)
  );
  slus_count u_bit (
    .major_in(vers_q[7:4]),
    .minor_in(vers_q[3:0]),
    .bar_out(bit_bar_w)
  );

  // ****************************************
  // sequencer
  // ****************************************
  reg [15:0] tmr_q;
  reg [3:0] idx_q;
  reg [15:0] fl_q;
  reg blink_q;
  reg drv_prev_q;
  wire [15:0] tmr_inc_w = tmr_q + 16'h0001;
  wire [11:0] walk_w = 12'h001 << idx_q;
  // main state machine and leds
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= S_BOOT;
      tmr_q <= 16'h0000;
      idx_q <= 4'h0;
      fl_q <= 16'h0000;
      blink_q <= 1'b0;
      drv_prev_q <= 1'b0;
      mcu_done_q <= 1'b0;
      bit_found_q <= 1'b0;
      bit_done_q <= 1'b0;
      nofile_q <= 1'b0;
      stat_done_q <= 1'b0;
      led_power_out <= 1'b0;
      led_usb_out <= 1'b0;
      led_sdi_out <= 1'b0;
      led_data_out <= 1'b0;
      led_audio_out <= 8'h00;
      mcu_load_req_out <= 1'b0;
      bit_load_req_out <= 1'b0;
      logic_reboot_out <= 1'b0;
      status_write_req_out <= 1'b0;
      image_load_en_out <= 1'b0;
      usb_host_en_out <= 1'b0;
      cfg_sw_out <= 8'h00;
    end else begin
      usb_host_en_out <= 1'b1;
      logic_reboot_out <= 1'b0;
      status_write_req_out <= 1'b0;
      drv_prev_q <= drv_ok_w;
      // status report on every flash drive attach
      if (drv_ok_w & ~drv_prev_q) begin
        status_write_req_out <= 1'b1; // [RQ15]
        stat_done_q <= 1'b1;
      end
      if (ms_w) tmr_q <= tmr_inc_w; // [RQ18]
      // blink base for load flashing
      if (ms_w) begin
        if (fl_q == FLASH_T - 16'h0001) begin
          fl_q <= 16'h0000;
          blink_q <= ~blink_q;
        end else begin
          fl_q <= fl_q + 16'h0001;
        end
      end
      case (st_q)
        S_BOOT: begin
          if (drv_ok_w & mcuf_w & ~mcu_done_q) begin
            mcu_load_req_out <= 1'b1; // [RQ11]
            if (mcud_w) begin
              mcu_load_req_out <= 1'b0;
              mcu_done_q <= 1'b1;
            end
          end else if (ms_w) begin
            // first tick leaves time for the pin synchronisers to settle
            st_q <= S_WALK;
            tmr_q <= 16'h0000;
            idx_q <= 4'h0;
          end
        end
        S_WALK: begin
          {led_audio_out, led_data_out, led_sdi_out, led_usb_out, led_power_out} <=
            walk_w[11:0]; // [RQ1]
          if (ms_w & (tmr_q == STEP_T - 16'h0001)) begin
            tmr_q <= 16'h0000;
            if (idx_q == LED_LAST) st_q <= S_GAP;
            else idx_q <= idx_q + 4'h1;
          end
        end
        S_GAP: begin
          led_audio_out <= 8'h00;
          led_power_out <= 1'b1; // [RQ2]
          led_usb_out <= 1'b0;
          if (ms_w & (tmr_q == GAP_T - 16'h0001)) begin
            st_q <= S_MCUV;
            tmr_q <= 16'h0000;
          end
        end
        S_MCUV: begin
          led_usb_out <= 1'b1; // [RQ3]
          led_audio_out <= mcu_bar_w; // [RQ4] [RQ5]
          if (ms_w & (tmr_q == SHOW_T - 16'h0001)) begin
            st_q <= S_BITV;
            tmr_q <= 16'h0000;
          end
        end
        S_BITV: begin
          led_usb_out <= 1'b0; // [RQ6]
          led_audio_out <= bit_bar_w;
          if (ms_w & (tmr_q == SHOW_T - 16'h0001)) begin
            st_q <= S_PAUSE;
            tmr_q <= 16'h0000;
          end
        end
        S_PAUSE: begin
          led_audio_out <= 8'h00;
          if (ms_w & (tmr_q == PAUSE_T - 16'h0001)) begin
            st_q <= S_NORM;
            if (drv_ok_w & bitf_w & ~bit_done_q) bit_found_q <= 1'b1;
            else nofile_q <= 1'b1;
          end
        end
        S_NORM: begin
          led_power_out <= 1'b1;
          led_usb_out <= drv_ok_w & xfer_w; // [RQ7]
          led_sdi_out <= ctrl_q[`SLUS_CTRL_OPTSEL] ? opt_w : coax_w; // [RQ8]
          led_data_out <= rs_w; // [RQ9]
          led_audio_out <= aud_w; // [RQ10]
          cfg_sw_out <= sw_w;
          // images load only when no firmware file is on the drive
          image_load_en_out <= drv_ok_w & ~bitf_w & ~mcuf_w; // [RQ16]
          if (bit_found_q & ~bit_done_q) begin
            st_q <= S_LOAD; // [RQ12]
            image_load_en_out <= 1'b0;
            fl_q <= 16'h0000; // blink starts with a full lit half period
            blink_q <= 1'b1;
          end
        end
        S_LOAD: begin
          bit_load_req_out <= 1'b1;
          led_usb_out <= blink_q; // [RQ13]
          led_sdi_out <= ctrl_q[`SLUS_CTRL_OPTSEL] ? opt_w : coax_w;
          if (bitd_w) begin
            st_q <= S_DONE;
            bit_load_req_out <= 1'b0;
            bit_done_q <= 1'b1;
            logic_reboot_out <= 1'b1; // [RQ14]
          end
        end
        S_DONE: begin
          led_usb_out <= 1'b1; // [RQ14]
          led_power_out <= 1'b1;
          led_sdi_out <= ctrl_q[`SLUS_CTRL_OPTSEL] ? opt_w : coax_w;
          led_data_out <= rs_w;
          led_audio_out <= aud_w;
          cfg_sw_out <= sw_w; // [RQ12]
        end
        default: st_q <= S_BOOT;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/slus_seq_chk.sv ***
`default_nettype none
// ****
// sequencer port checks
// ****
module slus_seq_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic led_power_out,
  input wire logic led_usb_out,
  input wire logic led_sdi_out,
  input wire logic led_data_out,
  input wire logic [7:0] led_audio_out,
  input wire logic mcu_load_req_out,
  input wire logic bit_load_req_out,
  input wire logic logic_reboot_out,
  input wire logic status_write_req_out,
  input wire logic image_load_en_out,
  input wire logic usb_host_en_out,
  input wire logic [7:0] cfg_sw_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // power off means boot or walk: one led at most
  a_walk_one_led: assert property (
    !led_power_out |-> $onehot0({led_usb_out, led_sdi_out, led_data_out, led_audio_out}))
    else $error("several leds lit before power led");
  a_power_holds: assert property (
    led_power_out && led_usb_out |=> led_power_out) else $error("power led dropped");
  a_bars_after_power: assert property (
    led_usb_out && led_audio_out != 8'h00 |-> led_power_out) else $error("bars without power");
  a_mcu_load_first: assert property (
    mcu_load_req_out |-> !led_power_out && !bit_load_req_out) else $error("load order wrong");
  a_cfg_frozen: assert property (
    bit_load_req_out && $past(bit_load_req_out) |-> $stable(cfg_sw_out))
    else $error("switches sampled during load");
  a_blink_half: assert property (
    bit_load_req_out && $rose(led_usb_out) |-> led_usb_out [*4]) else $error("blink too short");
  a_reboot_steady: assert property (
    logic_reboot_out |=> !logic_reboot_out ##[0:2] led_usb_out) else $error("reboot wrong");
  a_status_pulse: assert property (
    status_write_req_out |=> !status_write_req_out) else $error("status pulse too long");
  a_host_enabled: assert property (
    mcu_load_req_out || bit_load_req_out |-> usb_host_en_out) else $error("host off in load");
  a_images_no_load: assert property (
    image_load_en_out |-> !bit_load_req_out && !mcu_load_req_out)
    else $error("images enabled during firmware load");
endmodule
bind slus_seq slus_seq_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .led_power_out(led_power_out), .led_usb_out(led_usb_out), .led_sdi_out(led_sdi_out),
  .led_data_out(led_data_out), .led_audio_out(led_audio_out),
  .mcu_load_req_out(mcu_load_req_out), .bit_load_req_out(bit_load_req_out),
  .logic_reboot_out(logic_reboot_out), .status_write_req_out(status_write_req_out),
  .image_load_en_out(image_load_en_out),
  .usb_host_en_out(usb_host_en_out), .cfg_sw_out(cfg_sw_out));
`default_nettype wire

// *** verif/slus_drive_model.sv ***
`default_nettype none
// ****
// flash drive, with or without both firmware images
// ****
module slus_drive_model #(
  parameter int MCU_CYC = 40,
  parameter int BIT_CYC = 120
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mcu_load_req_in,
  input wire logic bit_load_req_in,
  input wire logic insert_in,
  input wire logic with_fw_in,
  output logic present_out,
  output logic mcu_file_out,
  output logic bit_file_out,
  output var logic mcu_done_out,
  output var logic bit_done_out,
  output var logic xfer_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_q;
  // presence follows insert_in directly; the flash flag comes from the bench
  assign present_out = insert_in;
  assign mcu_file_out = insert_in & with_fw_in;
  assign bit_file_out = insert_in & with_fw_in;
  // loads take a fixed time; done held while still requested
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 0;
      mcu_done_out <= 1'b0;
      bit_done_out <= 1'b0;
      xfer_out <= 1'b0;
    end else begin
      cnt_q <= (mcu_load_req_in || bit_load_req_in) ? cnt_q + 1 : 0;
      mcu_done_out <= mcu_load_req_in && cnt_q >= MCU_CYC;
      bit_done_out <= bit_load_req_in && cnt_q >= BIT_CYC;
      xfer_out <= bit_load_req_in && cnt_q < BIT_CYC;
    end
  end
endmodule
`default_nettype wire

// *** verif/slus_seq_tb_top.sv ***
`default_nettype none
// ****
// sequencer bench
// ****
module slus_seq_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, perr, sdi_c = 0, sdi_o = 0;
  logic rs485 = 0, pready, pslverr, pwr, usb, sdi, dat, mreq, breq, boot, pres, mf, bf, md, bd, xf;
  logic [11:0] paddr = 12'h000, walk;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [7:0] audio = 8'h00, cfg = 8'h00, aud, cfg_o;
  logic ins = 1, fw = 1, flash = 1, stw, ild, prev;
  int errors = 0, n_checks = 0, n, i, tog, n_stw;
  assign walk = {aud, dat, sdi, usb, pwr};
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  // count status report requests since the last reset
  always @(posedge clk_in) begin
    if (rst_in) n_stw <= 0;
    else if (stw === 1'b1) n_stw <= n_stw + 1;
  end
  slus_seq #(.STEP_MS(2), .SHOW_MS(3), .PAUSE_MS(3), .GAP_MS(3), .FLASH_MS(3), .MS_DIV(4)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .drive_present_in(pres),
    .drive_is_flash_in(flash), .mcu_file_in(mf), .mcu_load_done_in(md), .bit_file_in(bf),
    .bit_load_done_in(bd), .xfer_active_in(xf), .sdi_coax_ok_in(sdi_c), .sdi_opt_ok_in(sdi_o),
    .rs485_local_in(rs485), .audio_present_in(audio), .cfg_sw_in(cfg), .led_power_out(pwr),
    .led_usb_out(usb), .led_sdi_out(sdi), .led_data_out(dat), .led_audio_out(aud),
    .mcu_load_req_out(mreq), .bit_load_req_out(breq), .logic_reboot_out(boot),
    .status_write_req_out(stw), .image_load_en_out(ild), .usb_host_en_out(),
    .cfg_sw_out(cfg_o));
  slus_drive_model u_drive (.clk_in(clk_in), .rst_in(rst_in), .mcu_load_req_in(mreq),
    .bit_load_req_in(breq), .insert_in(ins), .with_fw_in(fw), .present_out(pres),
    .mcu_file_out(mf), .bit_file_out(bf),
    .mcu_done_out(md), .bit_done_out(bd), .xfer_out(xf));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 3000) begin
      errors++;
      $display("Error at %0t: wait timed out", $time);
      tally_and_finish;
    end
  endtask
  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 3000);
    bound(k);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // version reset value, unmapped access, new version for the display
  task automatic t_regs;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_1010);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(perr, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_4324);
  endtask
  // walk order, then controller 4.3 and logic 2.4 bars
  task automatic t_powerup;
    for (n = 0; n < 3000 && walk !== 12'h001; n++) @(posedge clk_in);
    bound(n);
    for (i = 1; i < 12; i++) begin
      for (n = 0; n < 3000 && walk === 12'h001 << (i - 1); n++) @(posedge clk_in);
      bound(n);
      chk(walk, 12'h001 << i);
    end
    for (n = 0; n < 3000 && usb !== 1'b1; n++) @(posedge clk_in);
    bound(n);
    @(posedge clk_in);
    chk(pwr, 1'b1);
    chk(aud, 8'hF7);
    for (n = 0; n < 3000 && usb !== 1'b0; n++) @(posedge clk_in);
    bound(n);
    @(posedge clk_in);
    chk(aud, 8'h3F);
  endtask
  // logic image load: blinking, frozen switches, reboot
  task automatic t_logic_load;
    for (n = 0; n < 3000 && breq !== 1'b1; n++) @(posedge clk_in);
    bound(n);
    cfg <= 8'h5A;
    tog = 0;
    prev = usb;
    for (n = 0; n < 3000 && boot !== 1'b1; n++) begin
      @(posedge clk_in);
      tog += (usb !== prev);
      prev = usb;
      if (breq === 1'b1 && boot !== 1'b1) chk(cfg_o, 8'h00);
    end
    bound(n);
    chk(tog >= 2, 1'b1);
    repeat (3) @(posedge clk_in);
    chk(usb, 1'b1);
    repeat (6) @(posedge clk_in);
    chk(cfg_o, 8'h5A);
  endtask
  // normal indication: input select, remote data, audio presence
  task automatic t_normal;
    apb(1'b1, 12'h000, 32'h0000_0000);
    sdi_c <= 1'b1;
    rs485 <= 1'b1;
    audio <= 8'hA5;
    repeat (6) @(posedge clk_in);
    chk(sdi, 1'b1);
    chk(dat, 1'b1);
    chk(aud, 8'hA5);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (6) @(posedge clk_in);
    chk(sdi, 1'b0);
    sdi_o <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(sdi, 1'b1);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd[4:0], 5'h17);
  endtask
  // second power-up with no drive, then a foreign device and an image-only drive
  task automatic t_reboot;
    rst_in <= 1'b1;
    ins <= 1'b0;
    fw <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({pwr, usb, aud}, 10'h000);
    rst_in <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, 12'h00C, 32'h0000_0000);
      n++;
    end while (rd[3] !== 1'b1 && n < 3000);
    bound(n);
    repeat (2) @(posedge clk_in);
    chk(rd[4:0], 5'h08);
    chk(pwr, 1'b1);
    chk(usb, 1'b0);
    chk(mreq, 1'b0);
    flash <= 1'b0;
    ins <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(n_stw, 0);
    chk(ild, 1'b0);
    ins <= 1'b0;
    repeat (2) @(posedge clk_in);
    flash <= 1'b1;
    ins <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(n_stw, 1);
    chk(ild, 1'b1);
    chk(usb, 1'b0);
    fw <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(ild, 1'b0);
    chk(breq, 1'b0);
  endtask
  // reset, then the scenarios in power-up order
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_powerup;
    t_logic_load;
    t_normal;
    t_reboot;
    tally_and_finish;
  end
endmodule
`default_nettype wire
